// ===== logic/sdfr_pkg.sv
// How it works
// R01: Host opens each frame by pulling frame select low; only that fall arms capture.
// R02: While select is low, each of the first sixteen falling serial clock edges shifts one data bit in.
// R03: The sixteenth falling edge captures the last bit and applies code and mode at once.
// R04: The first two frame bits form the operating mode field.
// R05: The next eight bits are the converter code; trailing bits are ignored.
// R06: Frames arrive most significant bit first.
// R07: Host raises select at least 20 ns before the next frame starts.
// R08: Select rising before the sixteenth edge clears the shift register and voids the frame.
// R09: An aborted frame leaves stored code and mode untouched.
// R10: Reset loads code zero and keeps it until a complete frame arrives.
// R11: Mode 00 is normal operation with the amplifier driving the output.
// R12: Mode 01 is 1 kOhm to ground, 10 is 100 kOhm, 11 is high impedance.
// R13: Any power-down mode shuts the amplifier and selects the termination network.
// R14: Power-down never alters the stored converter code.
// R15: The code is straight unsigned binary from 0 to 255.
// R16: After commit, further clock edges are ignored until select rises and falls again.
`default_nettype none
package sdfr_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 5;
  localparam int CODE_W     = 8;
  localparam int MODE_W     = 2;
  localparam int MODE_HI    = 15;
  localparam int MODE_LO    = 14;
  localparam int CODE_HI    = 13;
  localparam int CODE_LO    = 6;

  localparam logic [CNT_W-1:0]      LAST_BIT   = 5'h0F;
  localparam logic [CNT_W-1:0]      CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0]      CNT_ONE    = 5'h01;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST  = 16'h0000;
  localparam logic [CODE_W-1:0]     CODE_RST   = 8'h00;

  typedef enum logic [MODE_W-1:0] {
    SDFR_MODE_NORMAL = 2'b00,
    SDFR_MODE_PD_1K  = 2'b01,
    SDFR_MODE_PD_100K = 2'b10,
    SDFR_MODE_PD_HIZ = 2'b11
  } sdfr_mode_e;

  typedef enum logic [1:0] {
    SDFR_ST_IDLE = 2'b00,
    SDFR_ST_SHIFT = 2'b01,
    SDFR_ST_DONE = 2'b10
  } sdfr_state_e;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    sdfr_mode_e        mode;
  } sdfr_word_s;

  typedef struct packed {
    logic amp_on;
    logic term_1k;
    logic term_100k;
    logic hiz;
  } sdfr_out_s;

  // The three pins travel together so that their samples stay aligned in time.
  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic din;
  } sdfr_pins_s;

  localparam sdfr_word_s WORD_RST = '{code: CODE_RST, mode: SDFR_MODE_NORMAL};

endpackage : sdfr_pkg
`default_nettype wire

// ===== logic/sdfr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sdfr_sync
  import sdfr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire sdfr_pins_s pins_in,
  output var  sdfr_pins_s pins_out
);

  typedef struct packed {
    sdfr_pins_s meta;
    sdfr_pins_s stable;
  } sdfr_sync_s;

  sdfr_sync_s st;
  sdfr_sync_s next_st;

  // Idle levels: clock high, select high, so reset does not fake an edge.
  localparam sdfr_pins_s PINS_IDLE = '{sclk: 1'b1, sync_n: 1'b1, din: 1'b0};

  always_comb begin
    next_st.meta   = pins_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st <= '{meta: PINS_IDLE, stable: PINS_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign pins_out = st.stable;

endmodule : sdfr_sync
`default_nettype wire

// ===== logic/sdfr_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module sdfr_receiver
  import sdfr_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              SCLK_IN,
  input  wire logic              SYNC_N_IN,
  input  wire logic              DIN_IN,
  output logic [CODE_W-1:0]      CODE_OUT,
  output logic                   PWR_MODE_BIT_HI_OUT,
  output logic                   PWR_MODE_BIT_LO_OUT,
  output logic                   AMP_ON_OUT,
  output logic                   TERM_1K_OUT,
  output logic                   TERM_100K_OUT,
  output logic                   HIZ_OUT,
  output logic                   UPDATE_OUT
);

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  sdfr_pins_s pins_raw;
  sdfr_pins_s pins;

  assign pins_raw = '{sclk: SCLK_IN, sync_n: SYNC_N_IN, din: DIN_IN};

  sdfr_sync u_sync (
    .clk_in   (CLK_IN),
    .rstn_in  (RSTN_IN),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    sdfr_pins_s              prev;
    sdfr_state_e             state;
    logic [FRAME_BITS-1:0]   shift;
    logic [CNT_W-1:0]        count;
    sdfr_word_s              word;
    sdfr_out_s               outs;
    logic                    update;
  } sdfr_core_s;

  sdfr_core_s st;
  sdfr_core_s next_st;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  // Idle levels: clock high, select high, so reset does not fake an edge.
  localparam sdfr_pins_s PINS_IDLE = '{sclk: 1'b1, sync_n: 1'b1, din: 1'b0};

  // Reset leaves the amplifier driving, which is what the normal mode selects.
  localparam sdfr_out_s  OUTS_RST  = '{
    amp_on:    1'b1,
    term_1k:   1'b0,
    term_100k: 1'b0,
    hiz:       1'b0
  };

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic edge_fell(input logic prev_lvl, input logic now_lvl);
    return prev_lvl & ~now_lvl;
  endfunction : edge_fell

  function automatic logic edge_rose(input logic prev_lvl, input logic now_lvl);
    return ~prev_lvl & now_lvl;
  endfunction : edge_rose

  function automatic sdfr_mode_e frame_mode(input logic [FRAME_BITS-1:0] frame);
    return sdfr_mode_e'(frame[MODE_HI:MODE_LO]); // see R04
  endfunction : frame_mode

  function automatic logic [CODE_W-1:0] frame_code(input logic [FRAME_BITS-1:0] frame);
    // Bits below the code field are don't-care and are dropped here.
    return frame[CODE_HI:CODE_LO]; // see R05, R15
  endfunction : frame_code

  function automatic sdfr_out_s decode_mode(input sdfr_mode_e m);
    sdfr_out_s o;
    o = '{amp_on: 1'b0, term_1k: 1'b0, term_100k: 1'b0, hiz: 1'b0};
    case (m)
      SDFR_MODE_NORMAL: begin
        o.amp_on = 1'b1;    // see R11
      end
      SDFR_MODE_PD_1K: begin
        o.term_1k = 1'b1;   // see R12, R13
      end
      SDFR_MODE_PD_100K: begin
        o.term_100k = 1'b1; // see R12, R13
      end
      SDFR_MODE_PD_HIZ: begin
        o.hiz = 1'b1;       // see R12, R13
      end
      default: begin
        // An unknown mode falls back to the termination that draws no current.
        o.hiz = 1'b1;
      end
    endcase
    return o;
  endfunction : decode_mode

  function automatic sdfr_word_s frame_word(input logic [FRAME_BITS-1:0] frame);
    sdfr_word_s w;
    w.code = frame_code(frame);
    w.mode = frame_mode(frame);
    return w;
  endfunction : frame_word

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  // Each edge is found against the previous sample, so it counts once however long
  // the new level then stands.
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic last_bit;

  assign sclk_fall = edge_fell(st.prev.sclk, pins.sclk);     // see R02
  assign sync_fall = edge_fell(st.prev.sync_n, pins.sync_n); // see R01
  assign sync_rise = edge_rose(st.prev.sync_n, pins.sync_n); // see R08
  assign last_bit  = (st.count == LAST_BIT);                 // see R03

  // ------------------------------------------------------------
  // Shift path
  // ------------------------------------------------------------
  // New bits enter at the bottom, so the first bit ends at the top.
  logic [FRAME_BITS-1:0] shifted;

  for (genvar b = 0; b < FRAME_BITS; b++) begin : g_shift
    if (b == 0) begin : g_head
      assign shifted[b] = pins.din;       // see R06
    end else begin : g_body
      assign shifted[b] = st.shift[b-1];  // see R02
    end
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin

    next_st        = st;
    next_st.prev   = pins;
    next_st.update = 1'b0;

    case (st.state)
      SDFR_ST_IDLE: begin
        if (sync_fall) begin // see R01
          next_st.state = SDFR_ST_SHIFT;
          next_st.count = CNT_ZERO;
          next_st.shift = SHIFT_RST;
        end
      end
      SDFR_ST_SHIFT: begin
        // A select rise and a clock fall in the same sample count as an abort.
        if (sync_rise) begin
          next_st.state = SDFR_ST_IDLE; // see R08
          next_st.shift = SHIFT_RST;    // see R08, R09
          next_st.count = CNT_ZERO;
        end else if (sclk_fall) begin
          next_st.shift = shifted;      // see R02
          next_st.count = st.count + CNT_ONE;
          if (last_bit) begin
            // Word and output stage change in the same register update.
            next_st.state  = SDFR_ST_DONE;                     // see R03
            next_st.word   = frame_word(shifted);              // see R04, R05, R15
            next_st.outs   = decode_mode(frame_mode(shifted)); // see R13
            next_st.update = 1'b1;                             // see R03
          end
        end
      end
      SDFR_ST_DONE: begin
        // Clock edges here are dropped; only a new select fall restarts.
        if (sync_rise) begin // see R16
          next_st.state = SDFR_ST_IDLE;
        end
      end
      default: begin
        next_st.state = SDFR_ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      st.prev   <= PINS_IDLE;
      st.state  <= SDFR_ST_IDLE;
      st.shift  <= SHIFT_RST;
      st.count  <= CNT_ZERO;
      st.word   <= WORD_RST; // see R10
      st.outs   <= OUTS_RST; // see R10, R11
      st.update <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Power-down changes the amplifier and termination flags; the code stays put.
  assign CODE_OUT            = st.word.code; // see R14
  assign PWR_MODE_BIT_HI_OUT = st.word.mode[1];
  assign PWR_MODE_BIT_LO_OUT = st.word.mode[0];
  assign AMP_ON_OUT          = st.outs.amp_on;
  assign TERM_1K_OUT         = st.outs.term_1k;
  assign TERM_100K_OUT       = st.outs.term_100k;
  assign HIZ_OUT             = st.outs.hiz;
  assign UPDATE_OUT          = st.update;

endmodule : sdfr_receiver
`default_nettype wire

// ===== bench/sdfr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sdfr_monitor
  import sdfr_pkg::*;
(
  input wire logic              CLK_IN,
  input wire logic              RSTN_IN,
  input wire logic              SCLK_IN,
  input wire logic              SYNC_N_IN,
  input wire logic              DIN_IN,
  input wire logic [CODE_W-1:0] CODE_OUT,
  input wire logic              PWR_MODE_BIT_HI_OUT,
  input wire logic              PWR_MODE_BIT_LO_OUT,
  input wire logic              AMP_ON_OUT,
  input wire logic              TERM_1K_OUT,
  input wire logic              TERM_100K_OUT,
  input wire logic              HIZ_OUT,
  input wire logic              UPDATE_OUT
);
  // ------
  // Shadow of the frame at the pins.
  // ------
  logic [4:0]  cnt;
  logic [15:0] sh;
  wire  [1:0]  mode = {PWR_MODE_BIT_HI_OUT, PWR_MODE_BIT_LO_OUT};
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || SYNC_N_IN) begin
      cnt <= 5'h00;
      sh  <= 16'h0000;
    end else if ($fell(SCLK_IN) && cnt != 5'h10) begin
      cnt <= cnt + 5'h01;
      sh  <= {sh[14:0], DIN_IN};
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_last; $fell(SCLK_IN) && !SYNC_N_IN && cnt == 5'h0F; endsequence
  sequence s_pulse; UPDATE_OUT ##1 !UPDATE_OUT; endsequence
  property p_commit; s_last |-> ##[2:4] s_pulse; endproperty
  a_commit: assert property (p_commit) else $error("no update");
  property p_word; UPDATE_OUT |-> {mode, CODE_OUT} == sh[15:6]; endproperty
  a_word: assert property (p_word) else $error("bad word");
  property p_once; UPDATE_OUT |-> cnt == 5'h10; endproperty
  a_once: assert property (p_once) else $error("stray update");
  property p_hold; !UPDATE_OUT |-> $stable({mode, CODE_OUT}); endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  property p_term; {AMP_ON_OUT, TERM_1K_OUT, TERM_100K_OUT, HIZ_OUT} == 4'h8 >> mode; endproperty
  a_term: assert property (p_term) else $error("bad stage");
  property p_abort; SYNC_N_IN [*5] |-> !UPDATE_OUT; endproperty
  a_abort: assert property (p_abort) else $error("idle update");
  property p_rst; disable iff (1'b0) !RSTN_IN |=> CODE_OUT == 8'h00 && AMP_ON_OUT; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_start; $rose(RSTN_IN) |-> !UPDATE_OUT && CODE_OUT == 8'h00; endproperty
  a_start: assert property (p_start) else $error("start state");
endmodule : sdfr_monitor
bind sdfr_receiver sdfr_monitor u_sdfr_monitor (.*);
`default_nettype wire

// ===== bench/sdfr_host.sv
`timescale 1ns/10ps
`default_nettype none
module sdfr_host (
  output var logic sclk_out,
  output var logic sync_n_out,
  output var logic din_out
);
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    din_out = 1'b0;
  end
  // Serial clock rests high between frames; data is inverted once released.
  task send(input logic [15:0] w, input int n);
    #3.3 sync_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_out = (i < 16) ? w[15 - i] : ~din_out;
      #62.5 sclk_out = 1'b0;
      #62.5 sclk_out = 1'b1;
    end
    #40 sync_n_out = 1'b1;
    din_out = ~din_out;
    #40;
  endtask : send
endmodule : sdfr_host
`default_nettype wire

// ===== bench/test_serial_dac_frame_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_dac_frame_receiver;
  import sdfr_pkg::*;
  logic        clk_in, rstn_in, sclk, sync_n, din, hi, lo, amp, t1k, t100k, hiz, upd;
  logic [7:0]  code;
  logic [13:0] state;
  int          miscompares, total_checks, updates, cycles;
  assign state = {hi, lo, code, amp, t1k, t100k, hiz};
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  sdfr_host u_sdfr_host (.sclk_out(sclk), .sync_n_out(sync_n), .din_out(din));
  sdfr_receiver u_sdfr_receiver (.CLK_IN(clk_in), .RSTN_IN(rstn_in), .SCLK_IN(sclk),
    .SYNC_N_IN(sync_n), .DIN_IN(din), .CODE_OUT(code), .PWR_MODE_BIT_HI_OUT(hi),
    .PWR_MODE_BIT_LO_OUT(lo), .AMP_ON_OUT(amp), .TERM_1K_OUT(t1k),
    .TERM_100K_OUT(t100k), .HIZ_OUT(hiz), .UPDATE_OUT(upd));
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (upd === 1'b1) updates <= updates + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  task chk(input string n, input logic [13:0] s, input logic [13:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [13:0] expv(input logic [1:0] m, input logic [7:0] c);
    return {m, c, 4'h8 >> m};
  endfunction : expv
  task results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task frame(input logic [15:0] w, input int n);
    u_sdfr_host.send(w, n);
    repeat (3) @(posedge clk_in);
  endtask : frame
  // Every mode with both ends of the code range.
  task t_modes;
    logic [2:0] m;
    int         u0;
    u0 = updates;
    for (m = 3'h0; m < 3'h4; m++) begin
      frame({m[1:0], 8'h55 * {6'h00, m[1:0]}, 6'h2A}, 16);
      chk("mode", state, expv(m[1:0], 8'h55 * {6'h00, m[1:0]}));
    end
    chk("updates", 14'(updates - u0), 14'h0004);
  endtask : t_modes
  task t_abort;
    int u0;
    u0 = updates;
    for (int n = 1; n < 16; n += 14) begin
      frame(16'h1555, n);
      chk("abort", state, expv(2'b11, 8'hFF));
    end
    chk("abort updates", 14'(updates - u0), 14'h0000);
  endtask : t_abort
  task t_extra;
    int u0;
    u0 = updates;
    // Sixteen further falls would commit a second word if the bit count wrapped.
    frame({2'b00, 8'hA9, 6'h00}, 32);
    chk("extra", state, expv(2'b00, 8'hA9));
    chk("extra updates", 14'(updates - u0), 14'h0001);
  endtask : t_extra
  // A reset in mid-run brings back code zero, and a cut frame must not move it.
  task t_reset;
    int u0;
    rstn_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk("rerun reset", state, expv(2'b00, 8'h00));
    u0 = updates;
    frame(16'hFFFF, 8);
    chk("reset hold", state, expv(2'b00, 8'h00));
    chk("reset updates", 14'(updates - u0), 14'h0000);
  endtask : t_reset
  initial begin
    {miscompares, total_checks, updates, cycles} = '0;
    rstn_in = 1'b0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk("reset", state, expv(2'b00, 8'h00));
    t_modes();
    t_abort();
    t_extra();
    t_reset();
    results();
  end
endmodule : test_serial_dac_frame_receiver
`default_nettype wire
